// ==== rtl/ir_timer_pkg.sv ====
/*
 Constants for the infrared counter/timer pair: register indices, field
 positions, reset values and mode encodings.
 Assumes a single 200 MHz system clock and an APB register slave.
*/
package ir_timer_pkg;

   // -------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // -------------------------------------------------------------------
   localparam logic [2:0] IDX_NARROW_CTRL = 3'h0;
   localparam logic [2:0] IDX_SHARED_CTRL = 3'h1;
   localparam logic [2:0] IDX_WIDE_CTRL = 3'h2;
   localparam logic [2:0] IDX_SYNC_CTRL = 3'h3;
   localparam logic [2:0] IDX_WIDE_RELOAD_HI = 3'h4;
   localparam logic [2:0] IDX_WIDE_RELOAD_LO = 3'h5;
   localparam logic [2:0] IDX_NARROW_RELOAD = 3'h6;
   localparam logic [2:0] IDX_LAST = 3'h6;
   localparam int ADDR_LSB = 2;
   localparam int ADDR_MSB = 4;

   // -------------------------------------------------------------------
   // Per-counter control fields (narrow_ctrl and wide_ctrl)
   // -------------------------------------------------------------------
   localparam int CTL_RUN = 7;
   localparam int CTL_SINGLE = 6;
   localparam int CTL_TIMEOUT = 5;
   localparam int CTL_CLK_HI = 4;
   localparam int CTL_CLK_LO = 3;
   localparam int CTL_TO_MASK = 1;
   localparam int CTL_PIN_EN = 0;

   // -------------------------------------------------------------------
   // Shared control fields
   // -------------------------------------------------------------------
   localparam int SH_MODE = 7;
   localparam int SH_COMBO = 6;
   localparam int SH_FUNC_HI = 5;
   localparam int SH_FUNC_LO = 4;
   localparam int SH_SUB_HI = 3;
   localparam int SH_SUB_LO = 2;
   localparam int SH_INIT_NARROW = 1;
   localparam int SH_INIT_WIDE = 0;
   localparam int FLAG_RISE = 1;
   localparam int FLAG_FALL = 0;

   // Sync control field
   localparam int SYNC_EN = 7;

   // -------------------------------------------------------------------
   // Encodings
   // -------------------------------------------------------------------
   localparam logic [1:0] SUB_NORMAL = 2'h0;
   localparam logic [1:0] SUB_PINGPONG = 2'h1;
   localparam logic [1:0] SUB_FORCE0 = 2'h2;
   localparam logic [1:0] SUB_FORCE1 = 2'h3;
   localparam logic [1:0] FN_AND = 2'h0;
   localparam logic [1:0] FN_OR = 2'h1;
   localparam logic [1:0] FN_NOR = 2'h2;
   localparam logic [1:0] FN_NAND = 2'h3;
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   localparam logic [1:0] FILT_NONE = 2'h0;
   localparam logic [1:0] FILT_4 = 2'h1;
   localparam logic [1:0] FILT_8 = 2'h2;

   // Glitch filter lengths in system clock cycles
   localparam logic [3:0] FILT_LEN_4 = 4'h4;
   localparam logic [3:0] FILT_LEN_8 = 4'h8;

   // Reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_RELOAD = 8'h00;

endpackage

// ==== rtl/ir_counter_timer_pair.sv ====
/*
 8-bit and 16-bit counter/timer pair for infrared transmit and demodulation,
 with its APB register slave.
 Assumes pin inputs synchronous to pclk; APB master holds requests until
 pready; pready is always high so every access completes in its access phase.
*/
// Decided for this implementation: register access over APB.
// Overview of operation
// R1 - Writing one to wide run bit starts the wide counter; zero keeps it idle.
// R2 - Transmit: single-pass bit zero reloads at terminal count, one halts.
// R3 - Disabled wide counter in normal/ping-pong outputs inverse of its initial bit.
// R4 - Submode 10 or 11 forces wide output to zero or one.
// R5 - On enable wide counter loads hi*256+lo and output takes initial level.
// R6 - At zero: toggle output, timeout pulse if unmasked, set timeout flag.
// R7 - Reload bytes take effect only at the next load.
// R8 - Ping-pong: hardware hands the run bit between counters alternately.
// R9 - Ping-pong: timeout flag set at every terminal count.
// R10 - Pin enable bit zero routes each counter output to its pin; the code enables each pin when its pin enable bit is one.
// R11 - Combined bit in transmit puts logic of both outputs on combo pin.
// R12 - Combining function: 00 AND, 01 OR, 10 NOR, 11 NAND; AND at reset.
// R13 - Transmit submode 00 normal, 01 ping-pong.
// R14 - Demod filter: 00 none, 01 four cycles, 10 eight cycles.
// R15 - Demod edge select: 00 falling, 01 rising, 10 both.
// R16 - Demod input from first pin when zero, alternate pin when one.
// R17 - Mode bit zero transmit, one demodulation; transmit at reset.
// R18 - Edge flags set on edge; write one clears, zero leaves unchanged.
// R19 - Transmit: two low shared bits give initial output levels, reset zero.
// R20 - Sync mode restarts narrow carrier together with wide counter load.
// R21 - Counters decrement per prescaled tick and detect terminal count at zero.
`timescale 1ns/1ps
module ir_counter_timer_pair
   import ir_timer_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pin_demod_a,
   input wire logic pin_demod_b,
   output logic pin_narrow_out,
   output logic pin_narrow_oe,
   output logic pin_wide_out,
   output logic pin_wide_oe,
   output logic pin_combo_out,
   output logic pin_combo_oe,
   output logic narrow_timeout_pulse,
   output logic wide_timeout_pulse
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] narrow_ctrl;
      logic [7:0] wide_ctrl;
      logic [7:0] shared_ctrl;
      logic [7:0] sync_ctrl;
      logic [7:0] wide_reload_hi;
      logic [7:0] wide_reload_lo;
      logic [7:0] narrow_reload;
      logic [1:0] edge_flags;
      logic [7:0] narrow_count;
      logic [15:0] wide_count;
      logic narrow_level;
      logic wide_level;
      logic [2:0] prescale;
      logic [3:0] filt_count;
      logic filt_level;
      logic narrow_out;
      logic narrow_oe;
      logic wide_out;
      logic wide_oe;
      logic combo_out;
      logic combo_oe;
      logic narrow_pulse;
      logic wide_pulse;
   } state_s;

   state_s s;
   state_s next_s;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Prescaler tick for clock select 1, 1/2, 1/4, 1/8
   function automatic logic tick_of(input logic [2:0] pre, input logic [1:0] sel);
      logic t;
      t = 1'b1;
      case (sel)
         2'h0: t = 1'b1;
         2'h1: t = (pre[0] == 1'b0);
         2'h2: t = (pre[1:0] == 2'h0);
         2'h3: t = (pre == 3'h0);
         default: t = 1'b1;
      endcase
      return t;
   endfunction

   // Address decode: register hit on an aligned, mapped word
   function automatic logic addr_hit(input logic [31:0] a);
      return (a[31:ADDR_MSB+1] == '0) && (a[1:0] == 2'h0)
         && (a[ADDR_MSB:ADDR_LSB] <= IDX_LAST);
   endfunction

   // Combination of both counter outputs
   function automatic logic combine(input logic [1:0] fn, input logic a, input logic b);
      logic r;
      r = 1'b0;
      case (fn)
         FN_AND: r = a & b;
         FN_OR: r = a | b;
         FN_NOR: r = ~(a | b);
         FN_NAND: r = ~(a & b);
         default: r = a & b;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------------
   logic [2:0] idx;
   logic hit;
   logic wr;
   logic transmit;
   logic [7:0] rd_byte;

   assign idx = paddr[ADDR_MSB:ADDR_LSB];
   assign hit = addr_hit(paddr);
   assign wr = psel && penable && pwrite && hit && pstrb[0];
   assign transmit = ~s.shared_ctrl[SH_MODE]; // R17
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;

   // Read mux; edge flags replace initial levels in demodulation mode
   always_comb
   begin
      rd_byte = 8'h00;
      case (idx)
         IDX_NARROW_CTRL: rd_byte = s.narrow_ctrl;
         IDX_SHARED_CTRL: rd_byte = transmit ? s.shared_ctrl
            : {s.shared_ctrl[7:2], s.edge_flags}; // R18
         IDX_WIDE_CTRL: rd_byte = s.wide_ctrl;
         IDX_SYNC_CTRL: rd_byte = s.sync_ctrl;
         IDX_WIDE_RELOAD_HI: rd_byte = s.wide_reload_hi;
         IDX_WIDE_RELOAD_LO: rd_byte = s.wide_reload_lo;
         IDX_NARROW_RELOAD: rd_byte = s.narrow_reload;
         default: rd_byte = 8'h00;
      endcase
   end

   assign prdata = (psel && hit) ? {24'h000000, rd_byte} : 32'h00000000;

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   logic tick_n;
   logic tick_w;
   logic pingpong;
   logic toggles;
   logic load_n;
   logic load_w;
   logic demod_in;
   logic [3:0] filt_len;
   logic rise;
   logic fall;
   logic [1:0] submode;

   always_comb
   begin
      next_s = s;
      load_n = 1'b0;
      load_w = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      filt_len = 4'h0;
      submode = s.shared_ctrl[SH_SUB_HI:SH_SUB_LO];
      pingpong = transmit && (submode == SUB_PINGPONG); // R13
      toggles = (submode == SUB_NORMAL) || (submode == SUB_PINGPONG);
      tick_n = tick_of(s.prescale, s.narrow_ctrl[CTL_CLK_HI:CTL_CLK_LO]);
      tick_w = tick_of(s.prescale, s.wide_ctrl[CTL_CLK_HI:CTL_CLK_LO]);
      next_s.prescale = s.prescale + 3'h1;
      next_s.narrow_pulse = 1'b0;
      next_s.wide_pulse = 1'b0;

      // Register writes
      if (wr)
      begin
         case (idx)
            IDX_NARROW_CTRL:
            begin
               next_s.narrow_ctrl = {pwdata[7:6], s.narrow_ctrl[CTL_TIMEOUT], pwdata[4:0]};
               if (pwdata[CTL_TIMEOUT])
                  next_s.narrow_ctrl[CTL_TIMEOUT] = 1'b0;
               load_n = pwdata[CTL_RUN] && !s.narrow_ctrl[CTL_RUN];
            end
            IDX_WIDE_CTRL:
            begin
               next_s.wide_ctrl = {pwdata[7:6], s.wide_ctrl[CTL_TIMEOUT], pwdata[4:0]}; // R1
               if (pwdata[CTL_TIMEOUT])
                  next_s.wide_ctrl[CTL_TIMEOUT] = 1'b0;
               load_w = pwdata[CTL_RUN] && !s.wide_ctrl[CTL_RUN]; // R1
            end
            IDX_SHARED_CTRL:
            begin
               if (transmit)
                  next_s.shared_ctrl = pwdata[7:0]; // R19
               else
               begin
                  next_s.shared_ctrl = {pwdata[7:2], s.shared_ctrl[1:0]};
                  next_s.edge_flags = s.edge_flags & ~pwdata[1:0]; // R18
               end
            end
            IDX_SYNC_CTRL: next_s.sync_ctrl = pwdata[7:0];
            IDX_WIDE_RELOAD_HI: next_s.wide_reload_hi = pwdata[7:0]; // R7
            IDX_WIDE_RELOAD_LO: next_s.wide_reload_lo = pwdata[7:0]; // R7
            IDX_NARROW_RELOAD: next_s.narrow_reload = pwdata[7:0];
            default: next_s = next_s;
         endcase
      end

      // Wide counter
      if (load_w)
      begin
         next_s.wide_count = {s.wide_reload_hi, s.wide_reload_lo}; // R5
         next_s.wide_level = s.shared_ctrl[SH_INIT_WIDE]; // R5
         if (s.sync_ctrl[SYNC_EN])
            load_n = 1'b1; // R20
      end
      else if (s.wide_ctrl[CTL_RUN] && tick_w)
      begin
         if (s.wide_count == 16'h0000) // R21
         begin
            if (toggles)
               next_s.wide_level = ~s.wide_level; // R6
            next_s.wide_ctrl[CTL_TIMEOUT] = 1'b1; // R6 R9
            next_s.wide_pulse = s.wide_ctrl[CTL_TO_MASK]; // R6
            if (pingpong)
            begin
               next_s.wide_ctrl[CTL_RUN] = 1'b0; // R8
               next_s.narrow_ctrl[CTL_RUN] = 1'b1; // R8
               next_s.narrow_count = s.narrow_reload;
            end
            else if (s.wide_ctrl[CTL_SINGLE] && transmit)
               next_s.wide_ctrl[CTL_RUN] = 1'b0; // R2
            else
               next_s.wide_count = {s.wide_reload_hi, s.wide_reload_lo}; // R2 R7
         end
         else
            next_s.wide_count = s.wide_count - 16'h0001; // R21
      end

      // Narrow counter
      if (load_n)
      begin
         next_s.narrow_count = s.narrow_reload;
         next_s.narrow_level = s.shared_ctrl[SH_INIT_NARROW]; // R20
      end
      else if (s.narrow_ctrl[CTL_RUN] && tick_n)
      begin
         if (s.narrow_count == 8'h00) // R21
         begin
            if (toggles)
               next_s.narrow_level = ~s.narrow_level;
            next_s.narrow_ctrl[CTL_TIMEOUT] = 1'b1; // R9
            next_s.narrow_pulse = s.narrow_ctrl[CTL_TO_MASK];
            if (pingpong)
            begin
               next_s.narrow_ctrl[CTL_RUN] = 1'b0; // R8
               next_s.wide_ctrl[CTL_RUN] = 1'b1; // R8
               next_s.wide_count = {s.wide_reload_hi, s.wide_reload_lo};
            end
            else if (s.narrow_ctrl[CTL_SINGLE] && transmit)
               next_s.narrow_ctrl[CTL_RUN] = 1'b0;
            else
               next_s.narrow_count = s.narrow_reload;
         end
         else
            next_s.narrow_count = s.narrow_count - 8'h01; // R21
      end

      // Output levels; forced codes override enable state
      if (transmit && (submode == SUB_FORCE0))
         next_s.wide_out = 1'b0; // R4
      else if (transmit && (submode == SUB_FORCE1))
         next_s.wide_out = 1'b1; // R4
      else if (s.wide_ctrl[CTL_RUN])
         next_s.wide_out = s.wide_level;
      else
         next_s.wide_out = ~s.shared_ctrl[SH_INIT_WIDE]; // R3
      next_s.narrow_out = s.narrow_ctrl[CTL_RUN] ? s.narrow_level
         : ~s.shared_ctrl[SH_INIT_NARROW];
      next_s.narrow_oe = s.narrow_ctrl[CTL_PIN_EN]; // R10
      next_s.wide_oe = s.wide_ctrl[CTL_PIN_EN]; // R10
      next_s.combo_oe = transmit && s.shared_ctrl[SH_COMBO]; // R11
      next_s.combo_out = combine(s.shared_ctrl[SH_FUNC_HI:SH_FUNC_LO],
         s.narrow_out, s.wide_out); // R11 R12

      // Demodulator input select and glitch filter
      demod_in = s.shared_ctrl[SH_COMBO] ? pin_demod_b : pin_demod_a; // R16
      case (submode)
         FILT_4: filt_len = FILT_LEN_4; // R14
         FILT_8: filt_len = FILT_LEN_8; // R14
         default: filt_len = 4'h0; // R14
      endcase
      if (demod_in == s.filt_level)
         next_s.filt_count = 4'h0;
      else if ((s.filt_count + 4'h1) >= filt_len)
      begin
         next_s.filt_count = 4'h0;
         next_s.filt_level = demod_in; // R14
         rise = demod_in;
         fall = ~demod_in;
      end
      else
         next_s.filt_count = s.filt_count + 4'h1;

      // Edge flags; a detected edge wins over a clear in the same cycle
      if (!transmit)
      begin
         case (s.shared_ctrl[SH_FUNC_HI:SH_FUNC_LO])
            EDGE_FALL: rise = 1'b0; // R15
            EDGE_RISE: fall = 1'b0; // R15
            EDGE_BOTH: rise = rise; // R15
            default:
            begin
               rise = 1'b0;
               fall = 1'b0;
            end
         endcase
         if (rise)
            next_s.edge_flags[FLAG_RISE] = 1'b1; // R18
         if (fall)
            next_s.edge_flags[FLAG_FALL] = 1'b1; // R18
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s <= '0;
         s.narrow_ctrl <= RST_CTRL;
         s.wide_ctrl <= RST_CTRL;
         s.shared_ctrl <= RST_CTRL; // R12 R13 R17 R19
         s.sync_ctrl <= RST_CTRL;
         s.wide_reload_hi <= RST_RELOAD;
         s.wide_reload_lo <= RST_RELOAD;
         s.narrow_reload <= RST_RELOAD;
      end
      else
         s <= next_s;
   end

   // Pin and pulse outputs straight from flip-flops
   assign pin_narrow_out = s.narrow_out;
   assign pin_narrow_oe = s.narrow_oe;
   assign pin_wide_out = s.wide_out;
   assign pin_wide_oe = s.wide_oe;
   assign pin_combo_out = s.combo_out;
   assign pin_combo_oe = s.combo_oe;
   assign narrow_timeout_pulse = s.narrow_pulse;
   assign wide_timeout_pulse = s.wide_pulse;

endmodule

// ==== sim/ir_pair_monitor.sv ====
/*
 Port checker for the infrared counter/timer pair.
 Assumes only the top ports are visible; bound to every instance below.
*/
`timescale 1ns/1ps
module ir_pair_monitor
   import ir_timer_pkg::*;
(
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [31:0] paddr,
   input logic [31:0] pwdata,
   input logic [3:0] pstrb,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   input logic pin_narrow_out,
   input logic pin_narrow_oe,
   input logic pin_wide_out,
   input logic pin_wide_oe,
   input logic pin_combo_out,
   input logic pin_combo_oe,
   input logic narrow_timeout_pulse,
   input logic wide_timeout_pulse
);
   // -------------------------------------------------------------------
   // Shadow copies of written control bytes
   // -------------------------------------------------------------------
   logic wr_ok, wr_narrow, wr_shared, wr_wide;
   logic [7:0] sh_shared, sh_narrow, sh_wide;
   logic [1:0] settle;

   // Committed write decode
   assign wr_ok = psel && penable && pwrite && pstrb[0] && paddr[31:5] == 27'h0
                  && paddr[1:0] == 2'h0;
   assign wr_narrow = wr_ok && paddr[4:2] == IDX_NARROW_CTRL;
   assign wr_shared = wr_ok && paddr[4:2] == IDX_SHARED_CTRL;
   assign wr_wide = wr_ok && paddr[4:2] == IDX_WIDE_CTRL;

   // Shadows and settle count
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sh_shared <= 8'h00;
         sh_narrow <= 8'h00;
         sh_wide <= 8'h00;
         settle <= 2'h3;
      end
      else
      begin
         if (wr_shared)
            sh_shared <= pwdata[7:0];
         if (wr_narrow)
            sh_narrow <= pwdata[7:0];
         if (wr_wide)
            sh_wide <= pwdata[7:0];
         if (wr_shared)
            settle <= 2'h0;
         else if (settle != 2'h3)
            settle <= settle + 2'h1;
      end
   end

   // Combining function of the two counter levels
   function automatic logic combine(input logic [1:0] f, input logic n, input logic w);
      case (f)
         FN_AND: combine = n & w;
         FN_OR: combine = n | w;
         FN_NOR: combine = ~(n | w);
         default: combine = ~(n & w);
      endcase
   endfunction

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   pready_high_a: assert property (psel && penable |-> pready)
      else $error("pready low in access phase");
   unmapped_err_a: assert property (psel && penable && (paddr[4:2] > IDX_LAST
      || paddr[1:0] != 2'h0 || paddr[31:5] != 27'h0) |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   reset_idle_a: assert property ($rose(presetn) |-> !pin_wide_oe && !pin_narrow_oe
      && !pin_combo_oe) else $error("pin enable high after reset");
   wide_pin_en_a: assert property (wr_wide ##1 !wr_wide [*2] |->
      pin_wide_oe == $past(pwdata[CTL_PIN_EN], 2)) else $error("wide pin enable wrong");
   narrow_pin_en_a: assert property (wr_narrow ##1 !wr_narrow [*2] |->
      pin_narrow_oe == $past(pwdata[CTL_PIN_EN], 2)) else $error("narrow pin enable wrong");
   combo_pin_en_a: assert property (wr_shared ##1 !wr_shared [*3] |->
      pin_combo_oe == ($past(pwdata[SH_COMBO], 3) && !$past(pwdata[SH_MODE], 3)))
      else $error("combined pin enable wrong");
   combo_logic_a: assert property (settle == 2'h3 && pin_combo_oe && $past(pin_combo_oe) |->
      pin_combo_out == combine(sh_shared[5:4], $past(pin_narrow_out), $past(pin_wide_out)))
      else $error("combined pin level wrong");
   wide_forced_a: assert property (settle == 2'h3 && !sh_shared[SH_MODE]
      && sh_shared[SH_SUB_HI] |-> pin_wide_out == sh_shared[SH_SUB_LO])
      else $error("forced wide level wrong");
   wide_mask_a: assert property (wide_timeout_pulse |-> $past(sh_wide[CTL_TO_MASK])
      || $past(sh_wide[CTL_TO_MASK], 2)) else $error("wide timeout pulse while masked");
   narrow_mask_a: assert property (narrow_timeout_pulse |-> $past(sh_narrow[CTL_TO_MASK])
      || $past(sh_narrow[CTL_TO_MASK], 2)) else $error("narrow timeout pulse while masked");
endmodule

bind ir_counter_timer_pair ir_pair_monitor mon (.*);

// ==== sim/ir_link_model.sv ====
/*
 Receiver-side line model feeding the two demodulator inputs.
 Assumes the bench requests levels; both lines idle high like pulled-up inputs.
*/
`timescale 1ns/1ps
module ir_link_model
(
   input logic pclk,
   input logic presetn,
   input logic drive_a,
   input logic drive_b,
   output logic pin_demod_a,
   output logic pin_demod_b
);
   // Lines follow requests one clock later
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_demod_a <= 1'b1;
         pin_demod_b <= 1'b1;
      end
      else
      begin
         pin_demod_a <= drive_a;
         pin_demod_b <= drive_b;
      end
   end
endmodule

// ==== sim/ir_counter_timer_pair_tb.sv ====
/*
 Self-checking bench for the infrared counter/timer pair over APB.
 Assumes the line model in ir_link_model and the bound port checker.
*/
`timescale 1ns/1ps
module ir_counter_timer_pair_tb
   import ir_timer_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic drv_a = 1'b1, drv_b = 1'b1;
   logic [31:0] prdata;
   logic pready, pslverr, pin_demod_a, pin_demod_b;
   logic pin_narrow_out, pin_narrow_oe, pin_wide_out, pin_wide_oe;
   logic pin_combo_out, pin_combo_oe, narrow_timeout_pulse, wide_timeout_pulse;
   logic [7:0] rd;
   logic err, exp1;
   int n_fail = 0, n_checks = 0;
   int cyc, n;

   always #2.5 pclk = ~pclk;

   ir_counter_timer_pair dut (.*);
   ir_link_model link (.pclk, .presetn, .drive_a(drv_a), .drive_b(drv_b), .pin_demod_a,
      .pin_demod_b);

   // -------------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------------
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [2:0] idx, input logic [7:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {27'h0, idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (k == 16)
      begin
         n_fail++;
         test_done();
      end
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Cycles until the next wide timeout pulse
   task automatic gap(output int c);
      for (c = 1; c <= 400; c++)
      begin
         @(posedge pclk);
         if (wide_timeout_pulse === 1'b1)
            return;
      end
      n_fail++;
      test_done();
   endtask

   // Low pulse of w cycles on one demodulator line, then settle
   task automatic dip(input logic on_b, input int w);
      @(posedge pclk);
      if (on_b)
         drv_b <= 1'b0;
      else
         drv_a <= 1'b0;
      repeat (w) @(posedge pclk);
      drv_a <= 1'b1;
      drv_b <= 1'b1;
      repeat (14) @(posedge pclk);
   endtask

   // Hang guard
   initial
   begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      test_done();
   end

   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i <= 6; i++)
      begin
         apb(1'b0, i[2:0], 8'h00);
         chk("reset value", RST_CTRL, rd);
      end
      apb(1'b0, 3'h7, 8'h00);
      chk("unmapped error", 16'h1, err);
      chk("idle wide out", 16'h1, pin_wide_out);
      apb(1'b1, IDX_SHARED_CTRL, 8'h01);
      repeat (3) @(posedge pclk);
      chk("idle wide out inverted", 16'h0, pin_wide_out);
      // Modulo-N run, period from hi*256+lo, reload rewritten mid-run
      apb(1'b1, IDX_WIDE_RELOAD_HI, 8'h01);
      apb(1'b1, IDX_WIDE_RELOAD_LO, 8'h09);
      apb(1'b1, IDX_WIDE_CTRL, 8'h83);
      repeat (2) @(posedge pclk);
      chk("wide out at load", 16'h1, pin_wide_out);
      gap(cyc);
      gap(cyc);
      chk("period before reload", 16'd266, cyc[15:0]);
      apb(1'b1, IDX_WIDE_RELOAD_HI, 8'h00);
      apb(1'b1, IDX_WIDE_RELOAD_LO, 8'h03);
      gap(cyc);
      gap(cyc);
      chk("period after reload", 16'd4, cyc[15:0]);
      apb(1'b0, IDX_WIDE_CTRL, 8'h00);
      chk("timeout flag", 16'h20, rd & 8'h20);
      // Single pass stops after one terminal count
      apb(1'b1, IDX_WIDE_CTRL, 8'h00);
      apb(1'b1, IDX_NARROW_CTRL, 8'hC2);
      apb(1'b1, IDX_WIDE_CTRL, 8'hC3);
      gap(cyc);
      n = 0;
      repeat (20) @(posedge pclk) n += (wide_timeout_pulse === 1'b1);
      chk("pulses after single", 16'h0, n[15:0]);
      apb(1'b0, IDX_WIDE_CTRL, 8'h00);
      chk("run cleared", 16'h0, rd & 8'h80);
      apb(1'b1, IDX_WIDE_CTRL, 8'h23);
      apb(1'b0, IDX_WIDE_CTRL, 8'h00);
      chk("flag cleared", 16'h0, rd & 8'hA0);
      // Forced wide levels against the opposite idle level
      for (int s = 2; s <= 3; s++)
      begin
         apb(1'b1, IDX_SHARED_CTRL, {4'h0, s[1:0], 1'b0, s[0]});
         repeat (3) @(posedge pclk);
         chk("forced wide", {15'h0, s[0]}, pin_wide_out);
      end
      // Combined pin over every function and input pair
      apb(1'b1, IDX_NARROW_CTRL, 8'h01);
      apb(1'b1, IDX_WIDE_CTRL, 8'h01);
      for (int f = 0; f < 4; f++)
         for (int v = 0; v < 4; v++)
         begin
            apb(1'b1, IDX_SHARED_CTRL, {2'b01, f[1:0], 2'b00, v[1:0]});
            repeat (4) @(posedge pclk);
            case (f)
               0: exp1 = ~v[1] & ~v[0];
               1: exp1 = ~v[1] | ~v[0];
               2: exp1 = v[1] & v[0];
               default: exp1 = v[1] | v[0];
            endcase
            chk("combined level", {15'h0, exp1}, pin_combo_out);
            chk("narrow idle level", {15'h0, ~v[1]}, pin_narrow_out);
         end
      chk("pin enables", 16'h7, {pin_narrow_oe, pin_wide_oe, pin_combo_oe});
      // Edge selection and flag clearing in demodulation
      for (int e = 0; e < 3; e++)
      begin
         apb(1'b1, IDX_SHARED_CTRL, {2'b10, e[1:0], 4'h3});
         dip(1'b0, 3);
         apb(1'b0, IDX_SHARED_CTRL, 8'h00);
         chk("edge flags", {8'h0, 2'b10, e[1:0], 2'b00, e != 0, e != 1}, rd);
         apb(1'b1, IDX_SHARED_CTRL, {2'b10, e[1:0], 4'h2});
         apb(1'b0, IDX_SHARED_CTRL, 8'h00);
         chk("rise flag cleared", {14'h0, 1'b0, e != 1}, rd[1:0]);
      end
      // Input select: only the alternate line is heard
      apb(1'b1, IDX_SHARED_CTRL, {2'b11, EDGE_BOTH, FILT_NONE, 2'h3});
      dip(1'b0, 3);
      apb(1'b0, IDX_SHARED_CTRL, 8'h00);
      chk("unselected line", 16'h0, rd[1:0]);
      dip(1'b1, 3);
      apb(1'b0, IDX_SHARED_CTRL, 8'h00);
      chk("selected line", 16'h3, rd[1:0]);
      // Glitch filter rejects short pulses, passes long ones
      for (int g = 1; g <= 2; g++)
      begin
         apb(1'b1, IDX_SHARED_CTRL, {2'b10, EDGE_BOTH, g[1:0], 2'h3});
         dip(1'b0, 4 * g - 2);
         apb(1'b0, IDX_SHARED_CTRL, 8'h00);
         chk("short pulse", 16'h0, rd[1:0]);
         dip(1'b0, 4 * g + 2);
         apb(1'b0, IDX_SHARED_CTRL, 8'h00);
         chk("long pulse", 16'h3, rd[1:0]);
      end
      test_done();
   end
endmodule
